// ===== src/adc_readout_pkg.sv
package adc_readout_pkg;

   // System clock, stands in for the conversion oscillator
   localparam int CLK_PERIOD_NS = 100;

   // Conversion time and test delay, in nanoseconds
   localparam int CONV_TIME_NS = 147_000_000;
   localparam int TEST_DELAY_NS = 12_000;
   // Whole data output window for 24 internal clocks
   localparam int DATA_OUT_NS = 620_000;

   // Frame layout
   localparam int FRAME_BITS = 24;
   localparam int RESULT_W = 23;
   localparam int FIFO_DEPTH = 8;

   // Cycle counts; least times round up, longest round down
   localparam int CONV_CYC = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TEST_CYC = (TEST_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SCK_HALF_CYC = DATA_OUT_NS / (2 * FRAME_BITS * CLK_PERIOD_NS);

   // Cycles after reset release before the clock strap is caught
   localparam int STRAP_CYC = 4;

   // Reset values of the pin drivers
   localparam logic SDO_RST = 1'b1;
   localparam logic SCK_RST = 1'b1;

   // Serial clock source
   typedef enum logic [0:0] {
      MODE_EXT = 1'b0,
      MODE_INT = 1'b1
   } sck_mode_e;

   // Conversion cycle states
   typedef enum logic [2:0] {
      ST_POR = 3'b000,
      ST_CONV = 3'b001,
      ST_SLEEP = 3'b010,
      ST_TEST = 3'b011,
      ST_OUT = 3'b100
   } cyc_state_e;

   // Pin levels that travel through the synchroniser together
   typedef struct packed {
      logic cs_b;
      logic sck;
   } link_in_s;

endpackage

// ===== src/adc_serial_readout.sv
`timescale 1ns/10ps

// Result buffer between the converter core and the shifter
module result_fifo #(
   parameter int WIDTH = 23,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_b_i,
   // Filling side
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   // Draining side
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_q [DEPTH];  // Storage words
   logic [AW-1:0] wr_q;  // Write pointer
   logic [AW-1:0] rd_q;  // Read pointer
   logic [CW-1:0] cnt_q;  // Words held
   logic push;
   logic pop;

   // Pointer step with wrap, used by both ends
   function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
      nxt = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
   endfunction

   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign out_data_o = mem_q[rd_q];

   // Storage write, no reset needed on data
   always_ff @(posedge clock_i) begin
      if (push) begin
         mem_q[wr_q] <= in_data_i;
      end
   end

   // Pointers, count and registered flags
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
         in_ready_o <= 1'b1;
         out_valid_o <= 1'b0;
      end else begin
         if (push) begin
            wr_q <= nxt(wr_q);
         end
         if (pop) begin
            rd_q <= nxt(rd_q);
         end
         // Full and empty follow the count after this edge
         if (push && !pop) begin
            cnt_q <= cnt_q + CW'(1);
            in_ready_o <= (cnt_q + CW'(1)) != CW'(DEPTH);
            out_valid_o <= 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - CW'(1);
            in_ready_o <= 1'b1;
            out_valid_o <= cnt_q != CW'(1);
         end
      end
   end
endmodule

module adc_serial_readout #(
   parameter int CONV_CYCLES = adc_readout_pkg::CONV_CYC
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_b_i,
   // Conversion results from the modulator side
   input wire logic res_valid_i,
   input wire logic [adc_readout_pkg::RESULT_W-1:0] res_data_i,
   output logic res_ready_o,
   // Serial pins, asynchronous to clock_i
   input wire logic cs_b_i,
   input wire logic sck_i,
   output logic sck_o,
   output logic sck_oe_o,
   output logic sck_pullup_o,
   output logic sdo_o,
   output logic sdo_oe_o,
   // Status
   output logic busy_o,
   output logic two_wire_o
);
   localparam int RW = adc_readout_pkg::RESULT_W;
   localparam int FB = adc_readout_pkg::FRAME_BITS;
   localparam int CCW = $clog2(CONV_CYCLES + 1);

   // Synchroniser stages and edge history
   adc_readout_pkg::link_in_s meta_q;  // First stage, read only by sync_q
   adc_readout_pkg::link_in_s sync_q;  // Safe levels
   adc_readout_pkg::link_in_s hist_q;  // Previous safe levels

   // Cycle control
   adc_readout_pkg::cyc_state_e state_q;
   adc_readout_pkg::sck_mode_e mode_q;
   logic [CCW-1:0] conv_cnt_q;  // Conversion progress
   logic [7:0] tmr_q;  // Test delay and half-period timer
   logic [4:0] bit_q;  // Edges seen in this frame
   logic [2:0] por_q;  // Strap wait
   logic [FB-1:0] shreg_q;  // Static output shift register
   logic two_wire_q;
   logic restore_q;  // Pull-up held on after a status pulse

   // Decoded pin events
   logic cs_low;
   logic cs_fall;
   logic cs_rise;
   logic sck_rise;
   logic sck_fall;
   logic conv_done;
   logic fifo_valid;
   logic [RW-1:0] fifo_data;
   logic fifo_pop;
   logic int_mode;

   assign cs_low = !sync_q.cs_b || two_wire_q;
   assign cs_fall = hist_q.cs_b && !sync_q.cs_b;
   assign cs_rise = !hist_q.cs_b && sync_q.cs_b && !two_wire_q;
   assign sck_rise = !hist_q.sck && sync_q.sck;
   assign sck_fall = hist_q.sck && !sync_q.sck;
   assign conv_done = conv_cnt_q == CCW'(CONV_CYCLES - 1);
   assign int_mode = mode_q == adc_readout_pkg::MODE_INT;
   // Results leave the buffer only when a conversion ends
   assign fifo_pop = state_q == adc_readout_pkg::ST_CONV && conv_done;

   // Buffer stalls the producer when full
   result_fifo #(
      .WIDTH(RW),
      .DEPTH(adc_readout_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clock_i(clock_i),
      .rst_b_i(rst_b_i),
      .in_valid_i(res_valid_i),
      .in_data_i(res_data_i),
      .in_ready_o(res_ready_o),
      .out_valid_o(fifo_valid),
      .out_data_o(fifo_data),
      .out_ready_i(fifo_pop)
   );

   // Two-stage synchroniser plus edge history
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         meta_q <= '{cs_b: 1'b1, sck: 1'b1};
         sync_q <= '{cs_b: 1'b1, sck: 1'b1};
         hist_q <= '{cs_b: 1'b1, sck: 1'b1};
      end else begin
         meta_q <= '{cs_b: cs_b_i, sck: sck_i};
         sync_q <= meta_q;
         hist_q <= sync_q;
      end
   end

   // Strap catch a few cycles after release, never under reset
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         por_q <= '0;
         two_wire_q <= 1'b0;
      end else if (state_q == adc_readout_pkg::ST_POR) begin
         por_q <= por_q + 3'h1;
         if (por_q == 3'(adc_readout_pkg::STRAP_CYC - 1)) begin
            two_wire_q <= !sync_q.sck;
         end
      end
   end

   // Clock source picked at each select fall after power-on; two-wire forces external
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         mode_q <= adc_readout_pkg::MODE_EXT;
      end else if (two_wire_q) begin
         mode_q <= adc_readout_pkg::MODE_EXT;
      end else if (cs_fall && state_q != adc_readout_pkg::ST_POR) begin
         // A pin held low by anyone means external
         mode_q <= sync_q.sck ? adc_readout_pkg::MODE_INT
                              : adc_readout_pkg::MODE_EXT;
      end
   end

   // Conversion timer, cleared outside the convert state
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         conv_cnt_q <= '0;
      end else if (state_q != adc_readout_pkg::ST_CONV) begin
         conv_cnt_q <= '0;
      end else if (!conv_done) begin
         conv_cnt_q <= conv_cnt_q + CCW'(1);
      end
   end

   // Main cycle: convert, sleep, status test, data output
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         state_q <= adc_readout_pkg::ST_POR;
         shreg_q <= '0;
         tmr_q <= '0;
         bit_q <= '0;
         sdo_o <= adc_readout_pkg::SDO_RST;
         sck_o <= adc_readout_pkg::SCK_RST;
      end else begin
         case (state_q)
            adc_readout_pkg::ST_POR: begin
               if (por_q == 3'(adc_readout_pkg::STRAP_CYC - 1)) begin
                  state_q <= adc_readout_pkg::ST_CONV;
               end
            end
            adc_readout_pkg::ST_CONV: begin
               // Busy reads one, extra clocks fall here
               sdo_o <= 1'b1;
               if (cs_fall && sync_q.sck && !two_wire_q) begin
                  sck_o <= 1'b0;
               end
               // An empty buffer holds the cycle until data lands
               if (conv_done && fifo_valid) begin
                  shreg_q <= {1'b0, fifo_data};
                  sdo_o <= 1'b0;
                  tmr_q <= '0;
                  if (cs_low && int_mode && !cs_fall) begin
                     sck_o <= 1'b0;
                     state_q <= adc_readout_pkg::ST_TEST;
                  end else begin
                     state_q <= adc_readout_pkg::ST_SLEEP;
                  end
               end
            end
            adc_readout_pkg::ST_SLEEP: begin
               sdo_o <= 1'b0;
               tmr_q <= '0;
               bit_q <= '0;
               if (cs_fall && sync_q.sck && !two_wire_q) begin
                  sck_o <= 1'b0;
                  state_q <= adc_readout_pkg::ST_TEST;
               end else if (cs_low && !int_mode && sck_rise) begin
                  state_q <= adc_readout_pkg::ST_OUT;
               end
            end
            adc_readout_pkg::ST_TEST: begin
               if (cs_rise) begin
                  // Result stays put for a later read
                  state_q <= adc_readout_pkg::ST_SLEEP;
               end else if (tmr_q == 8'(adc_readout_pkg::TEST_CYC - 1)) begin
                  sck_o <= 1'b1;  // First internal rise
                  tmr_q <= '0;
                  bit_q <= 5'h01;
                  state_q <= adc_readout_pkg::ST_OUT;
               end else begin
                  tmr_q <= tmr_q + 8'h01;
               end
            end
            adc_readout_pkg::ST_OUT: begin
               if (cs_rise) begin
                  // Abort drops the rest of the frame
                  sdo_o <= 1'b1;
                  state_q <= adc_readout_pkg::ST_CONV;
               end else if (!int_mode) begin
                  if (sck_fall) begin
                     shreg_q <= {shreg_q[FB-2:0], 1'b1};
                     sdo_o <= shreg_q[FB-2];
                     bit_q <= bit_q + 5'h01;
                     if (bit_q == 5'(FB - 1)) begin
                        sdo_o <= 1'b1;
                        state_q <= adc_readout_pkg::ST_CONV;
                     end
                  end
               end else if (tmr_q ==
                            8'(adc_readout_pkg::SCK_HALF_CYC - 1)) begin
                  tmr_q <= '0;
                  if (sck_o) begin
                     // Internal fall moves the next bit out
                     sck_o <= 1'b0;
                     shreg_q <= {shreg_q[FB-2:0], 1'b1};
                     sdo_o <= shreg_q[FB-2];
                  end else if (bit_q == 5'(FB - 1)) begin
                     // Last rise, clock then parks high
                     sck_o <= 1'b1;
                     state_q <= adc_readout_pkg::ST_CONV;
                  end else begin
                     sck_o <= 1'b1;
                     bit_q <= bit_q + 5'h01;
                  end
               end else begin
                  tmr_q <= tmr_q + 8'h01;
               end
            end
            default: begin
               state_q <= adc_readout_pkg::ST_POR;
            end
         endcase
      end
   end

   // The host waits for the last rise before data goes high
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         busy_o <= 1'b1;
      end else begin
         busy_o <= state_q == adc_readout_pkg::ST_CONV
                   || state_q == adc_readout_pkg::ST_POR;
      end
   end

   // Data pin enable follows select, or is held on in two-wire mode; off in power-on
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         sdo_oe_o <= 1'b0;
      end else begin
         sdo_oe_o <= cs_low && state_q != adc_readout_pkg::ST_POR;
      end
   end

   // Clock pin is driven only in internal mode with select low
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         sck_oe_o <= 1'b0;
      end else begin
         sck_oe_o <= int_mode && !sync_q.cs_b && !two_wire_q
                     && state_q != adc_readout_pkg::ST_POR;
      end
   end

   // Weak pull-up: on during reset, off once the pin is seen low, but held on after a status pulse until the pin reads high
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         sck_pullup_o <= 1'b1;
         restore_q <= 1'b0;
      end else if (cs_rise && state_q == adc_readout_pkg::ST_TEST) begin
         sck_pullup_o <= 1'b1;
         restore_q <= 1'b1;
      end else if (restore_q) begin
         // Our own low drive is still in the synchroniser; wait for a high pin
         sck_pullup_o <= 1'b1;
         restore_q <= !sync_q.sck && sync_q.cs_b;
      end else if (!sync_q.sck) begin
         // Pin low with nobody pulling: stays low
         sck_pullup_o <= 1'b0;
      end else begin
         sck_pullup_o <= 1'b1;
      end
   end

   // Strap result as a status level
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         two_wire_o <= 1'b0;
      end else begin
         two_wire_o <= two_wire_q;
      end
   end
endmodule

// ===== bench/adc_serial_readout_properties.sv
`timescale 1ns/10ps
// Pin-level checks on the readout, ports of the top module only
module adc_readout_checker #(
   parameter int CONV_CYCLES = 200
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_b_i,
   // Watched ports
   input wire logic res_ready_o,
   input wire logic cs_b_i,
   input wire logic sck_i,
   input wire logic sck_o,
   input wire logic sck_oe_o,
   input wire logic sck_pullup_o,
   input wire logic sdo_o,
   input wire logic sdo_oe_o,
   input wire logic busy_o,
   input wire logic two_wire_o
);
   int busy_q; // Cycles busy has stood high
   int low_q; // Cycles the device holds its clock low while idle
   int rise_q; // Clock rises in the current frame

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);

   // Counters restart on reset so a second reset cannot leave stale counts
   always_ff @(posedge clock_i) begin
      busy_q <= (rst_b_i && busy_o) ? busy_q + 1 : 0;
   end
   // Low time of a device-driven clock outside conversion
   always_ff @(posedge clock_i) begin
      low_q <= (rst_b_i && sck_oe_o && !sck_o && !busy_o) ? low_q + 1 : 0;
   end
   // Rises of the device clock within one frame
   always_ff @(posedge clock_i) begin
      rise_q <= (!rst_b_i || !sck_oe_o || busy_o) ? 0 : rise_q + int'($rose(sck_o));
   end

   a_sdo_float: assert property ((!two_wire_o && cs_b_i) [*6] |-> !sdo_oe_o)
      else $error("data pin driven while deselected");
   a_busy_sdo: assert property ($rose(busy_o) && sdo_oe_o |-> sdo_o [*3])
      else $error("data pin not high as conversion starts");
   a_conv_length: assert property ($fell(busy_o) |-> busy_q >= CONV_CYCLES - 1)
      else $error("conversion ended early");
   a_pullup_low: assert property ((!cs_b_i && !sck_i && !busy_o) [*5] |-> !sck_pullup_o)
      else $error("pull-up on while clock low");
   a_int_clock_low: assert property (
      $fell(cs_b_i) && sck_i && !two_wire_o |-> ##[2:5] (sck_oe_o && !sck_o))
      else $error("clock not driven low after select");
   a_test_delay: assert property (
      $rose(sck_o) && sck_oe_o && !busy_o && !cs_b_i
      |-> low_q >= adc_readout_pkg::TEST_CYC - 2
          && low_q <= adc_readout_pkg::SCK_HALF_CYC + 2)
      else $error("clock low time off");
   a_last_rise: assert property (
      $rose(sck_o) && sck_oe_o && rise_q == 23 |-> ##[0:4] busy_o)
      else $error("no conversion after last rise");
   a_frame_rises: assert property (rise_q <= 24)
      else $error("more than a frame of clocks");
   a_reset_vals: assert property (
      $rose(rst_b_i) |-> busy_o && !sdo_oe_o && !sck_oe_o && sck_pullup_o && res_ready_o)
      else $error("outputs not at reset values");
   // Status pulse released with clock low: pull-up must hold while the pin rises
   a_pullup_restore: assert property (
      $fell(sck_oe_o) && !sck_o && !sdo_o && !busy_o |-> sck_pullup_o [*3])
      else $error("pull-up not restored after status pulse");

   c_conv_done: cover property ($fell(busy_o));
   c_int_frame: cover property ($rose(sck_o) && sck_oe_o && rise_q == 23);
   c_full: cover property (!res_ready_o);
endmodule

// ===== bench/adc_host_model.sv
`timescale 1ns/10ps
// Serial master on the readout pins; resolves the clock wire
module adc_host_model (
   // Clock
   input wire logic clock_i,
   // Device pin drivers
   input wire logic sck_i,
   input wire logic sck_oe_i,
   input wire logic pullup_i,
   input wire logic sdo_i,
   input wire logic sdo_oe_i,
   // Wire levels
   output logic cs_b_o,
   output logic sck_w_o,
   output logic sdo_w_o
);
   logic drv_en = 1'b0; // Host drives the clock wire
   logic drv_v = 1'b0; // Host clock level
   logic sck_last_q = 1'b1; // Last driven clock level
   logic sdo_last_q = 1'b1; // Last driven data level

   initial cs_b_o = 1'b1;

   // Undriven wires drift away from their last level unless pulled up
   always_ff @(posedge clock_i) sck_last_q <= (sck_oe_i || drv_en) ? sck_w_o : sck_last_q;
   always_ff @(posedge clock_i) sdo_last_q <= sdo_oe_i ? sdo_i : sdo_last_q;
   assign sck_w_o = sck_oe_i ? sck_i : drv_en ? drv_v : pullup_i ? 1'b1 : ~sck_last_q;
   assign sdo_w_o = sdo_oe_i ? sdo_i : ~sdo_last_q;

   task automatic ticks(input int n);
      repeat (n) @(negedge clock_i);
   endtask
   // Chip select level
   task automatic select(input logic v);
      @(negedge clock_i);
      cs_b_o = v;
   endtask
   // Low before select or reset picks external clocking
   task automatic hold_sck(input logic en);
      @(negedge clock_i);
      drv_en = en;
      drv_v = 1'b0;
   endtask
   // External clocks of 800 ns, bit taken at each rise
   task automatic ext_clocks(input int n, output logic [31:0] got);
      got = '0;
      for (int i = 0; i < n; i++) begin
         ticks(1);
         drv_v = 1'b1;
         got = {got[30:0], sdo_w_o};
         ticks(4);
         drv_v = 1'b0;
         ticks(3);
      end
   endtask
   // Device-made clocks; caller raises select only with clock high
   task automatic int_clocks(input int n, output logic [31:0] got, output logic late);
      int t;
      got = '0;
      late = 1'b0;
      for (int i = 0; i < n; i++) begin
         t = 0;
         while (sck_w_o !== 1'b0 && t < 1000) begin
            ticks(1);
            t++;
         end
         while (sck_w_o !== 1'b1 && t < 1000) begin
            ticks(1);
            t++;
         end
         late = late | (t >= 1000);
         got = {got[30:0], sdo_w_o};
      end
   endtask
endmodule

// ===== bench/tb_adc_serial_readout.sv
`timescale 1ns/10ps
// Results in, frames out, compared against the pushed words
module tb_adc_serial_readout;
   logic clock_i = 1'b0; // System clock
   logic rst_b_i = 1'b0; // Reset
   logic res_valid_i = 1'b0; // Result offer
   logic [adc_readout_pkg::RESULT_W-1:0] res_data_i = '0; // Result word
   wire res_ready_o, sck_o, sck_oe_o, sck_pullup_o, sdo_o, sdo_oe_o, busy_o, two_wire_o;
   wire cs_b, sck_w, sdo_w; // Wire levels
   int failures = 0;
   int total_checks = 0;
   int seed = 83;
   int k;
   logic late;
   logic [31:0] got;
   logic [22:0] exp_q[$]; // Words not yet read, oldest first

   always #50 clock_i = ~clock_i;

   adc_serial_readout #(.CONV_CYCLES(200)) adc_serial_readout_i (.clock_i(clock_i),
      .rst_b_i(rst_b_i), .res_valid_i(res_valid_i), .res_data_i(res_data_i),
      .res_ready_o(res_ready_o), .cs_b_i(cs_b), .sck_i(sck_w), .sck_o(sck_o),
      .sck_oe_o(sck_oe_o), .sck_pullup_o(sck_pullup_o), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
      .busy_o(busy_o), .two_wire_o(two_wire_o));
   adc_host_model adc_host_model_i (.clock_i(clock_i), .sck_i(sck_o), .sck_oe_i(sck_oe_o),
      .pullup_i(sck_pullup_o), .sdo_i(sdo_o), .sdo_oe_i(sdo_oe_o), .cs_b_o(cs_b),
      .sck_w_o(sck_w), .sdo_w_o(sdo_w));

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude();
      if (failures == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clock_i);
   endtask
   // Bounded wait for the busy flag
   task automatic wait_busy(input logic v);
      int t;
      t = 0;
      while (busy_o !== v && t < 2000) begin
         tick(1);
         t++;
      end
      if (t >= 2000) begin
         failures++;
         conclude();
      end
   endtask
   // Device-clocked read; a stalled clock ends the run
   task automatic int_read(input int n);
      adc_host_model_i.int_clocks(n, got, late);
      if (late) begin
         failures++;
         conclude();
      end
   endtask
   // Reset with the clock wire low or pulled up
   task automatic do_reset(input logic two);
      rst_b_i = 1'b0;
      exp_q.delete();
      tick(20);
      rst_b_i = 1'b1;
      chk("busy at reset", 1, busy_o);
      tick(8);
      chk("two-wire strap", {31'h0, two}, {31'h0, two_wire_o});
   endtask
   // Back-to-back random words
   task automatic fill(input int n);
      for (int i = 0; i < n; i++) begin
         tick(1);
         res_valid_i = 1'b1;
         res_data_i = 23'($random(seed));
         exp_q.push_back(res_data_i);
      end
      tick(1);
      res_valid_i = 1'b0;
   endtask
   // Flag, word, then ones for clocks past the frame
   function automatic logic [31:0] frame(input logic [22:0] w, input int n);
      return {1'b0, w, 8'hFF} >> (32 - n);
   endfunction

   initial begin
      do_reset(1'b0);
      fill(8);
      tick(2);
      res_valid_i = 1'b1;
      res_data_i = 23'h7FFFFF;
      tick(1);
      chk("buffer full", 0, res_ready_o);
      res_valid_i = 1'b0;
      chk("deselected", 0, sdo_oe_o);
      // External clocking, select with the clock low
      adc_host_model_i.hold_sck(1'b1);
      adc_host_model_i.select(1'b0);
      tick(6);
      chk("flag busy", 1, sdo_w);
      wait_busy(1'b0);
      tick(4);
      chk("flag ready", 0, sdo_w);
      adc_host_model_i.ext_clocks(32, got);
      chk("ext frame", frame(exp_q.pop_front(), 32), got);
      chk("ext convert", 1, busy_o);
      wait_busy(1'b0);
      k = 1 + ($unsigned($random(seed)) % 23);
      adc_host_model_i.ext_clocks(k, got);
      chk("ext partial", frame(exp_q.pop_front(), k), got);
      adc_host_model_i.select(1'b1);
      tick(6);
      chk("ext abort", 1, busy_o);
      chk("released", 0, sdo_oe_o);
      // Internal clocking: clock wire left to the pull-up
      adc_host_model_i.hold_sck(1'b0);
      wait_busy(1'b0);
      adc_host_model_i.select(1'b0);
      tick(40);
      chk("status clock", 0, sck_w);
      chk("status flag", 0, sdo_w);
      adc_host_model_i.select(1'b1);
      tick(10);
      chk("back asleep", 0, busy_o);
      chk("pull-up back", 1, sck_pullup_o);
      adc_host_model_i.select(1'b0);
      int_read(24);
      chk("int frame", frame(exp_q.pop_front(), 24), got);
      tick(10);
      chk("int convert", 1, busy_o);
      chk("int clock high", 1, sck_w);
      k = 2 + ($unsigned($random(seed)) % 20);
      int_read(k);
      chk("int partial", frame(exp_q.pop_front(), k), got);
      adc_host_model_i.select(1'b1);
      tick(8);
      chk("int abort", 1, busy_o);
      // Two-wire: clock low through reset, select tied low
      adc_host_model_i.hold_sck(1'b1);
      adc_host_model_i.select(1'b0);
      do_reset(1'b1);
      fill(2);
      wait_busy(1'b0);
      adc_host_model_i.ext_clocks(24, got);
      chk("two-wire frame", frame(exp_q.pop_front(), 24), got);
      tick(4);
      chk("two-wire restart", 1, sdo_w);
      conclude();
   end
endmodule

bind adc_serial_readout adc_readout_checker #(.CONV_CYCLES(CONV_CYCLES)) adc_readout_checker_i (
   .clock_i(clock_i), .rst_b_i(rst_b_i), .res_ready_o(res_ready_o), .cs_b_i(cs_b_i),
   .sck_i(sck_i), .sck_o(sck_o), .sck_oe_o(sck_oe_o), .sck_pullup_o(sck_pullup_o),
   .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .busy_o(busy_o), .two_wire_o(two_wire_o));
